// file: logic/serial_port_error_pkg.sv
package serial_port_error_pkg;
	// Register byte offsets on the APB side
	localparam logic [7:0] ADDR_MCS       = 8'h00;
	localparam logic [7:0] ADDR_STATUS    = 8'h04;
	localparam logic [7:0] ADDR_DETECT    = 8'h08;
	localparam logic [7:0] ADDR_CTRL      = 8'h0c;
	localparam logic [7:0] ADDR_RATE      = 8'h10;
	localparam logic [7:0] ADDR_THRESH    = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1c;

	// multicast_symbol_send_reg fields
	localparam int MCS_SEND_BIT = 0;
	localparam int MCS_DONE_BIT = 1;
	localparam logic MCS_DONE_RST = 1'b1;

	// port_error_status_reg fields
	localparam int ST_UP_EVEN   = 0;
	localparam int ST_ERR_EVEN  = 1;
	localparam int ST_PW_EVEN   = 4;
	localparam int ST_UP_ODD    = 8;
	localparam int ST_ERR_ODD   = 9;
	localparam int ST_PW_ODD    = 12;
	localparam int ST_OES       = 16;

	// Error detect register fields
	localparam int DET_ERR_EVEN = 0;
	localparam int DET_VND_EVEN = 1;
	localparam int DET_ERR_ODD  = 8;
	localparam int DET_VND_ODD  = 9;

	// Port control register fields
	localparam int CTL_DROP_EN   = 0;
	localparam int CTL_STOP_FAIL = 1;
	localparam int CTL_DEAD_EN   = 2;
	localparam int CTL_LOCK      = 3;
	localparam int CTL_PERR_EN   = 4;
	localparam int CTL_PORT_WRITE_DISABLE    = 5;
	localparam int CTL_NARROW    = 6;
	localparam int CTL_DUAL      = 7;
	localparam int CTRL_W        = 8;
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

	// Error rate threshold
	localparam int RATE_W = 8;
	localparam logic [RATE_W-1:0] THRESH_RST = 8'hff;

	// Interrupt status and mask bits
	localparam int IRQ_W        = 5;
	localparam int IRQ_ERR_EVEN = 0;
	localparam int IRQ_ERR_ODD  = 1;
	localparam int IRQ_RATE     = 2;
	localparam int IRQ_LATE     = 3;
	localparam int IRQ_MCS      = 4;
	localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

	// Lanes and lane enables
	localparam int LANES = 4;
	localparam logic [LANES-1:0] TX_ONE  = 4'h1;
	localparam logic [LANES-1:0] TX_DUAL = 4'h3;
	localparam logic [LANES-1:0] TX_ALL  = 4'hf;

	// Deadline for software to set the lock bit after a port-write
	localparam int CLK_PERIOD_NS     = 5;
	localparam int LOCK_DEADLINE_US  = 80;
	localparam int LOCK_DEADLINE_CYC = LOCK_DEADLINE_US * 1000 / CLK_PERIOD_NS;
	localparam int DL_W = 16;

	// Start-up signal monitor states
	typedef enum logic [2:0] {
		MON_IDLE = 3'b001,
		MON_SEEN = 3'b010,
		MON_LOST = 3'b100
	} monitor_state_type;
endpackage : serial_port_error_pkg

// file: logic/port_err_if.sv
`timescale 1ns/1ps
interface port_err_if;
	logic [3:0] lane_sync;    // 10b sync per lane
	logic [3:0] lane_cause;   // Raw error cause per lane
	logic       lane_hit;     // Qualified OR of lane causes
	logic       sig_present;  // Receiver signal detect
	logic       link_up;      // Port has reached link-up
	logic       sig_returned; // Signal came back after loss
	modport merge (input lane_sync, input lane_cause, output lane_hit);
	modport monitor (input sig_present, input link_up, output sig_returned);
	modport core (output lane_sync, output lane_cause, output sig_present,
		output link_up, input lane_hit, input sig_returned);
endinterface : port_err_if

// file: logic/lane_error_merge.sv
`timescale 1ns/1ps
module lane_error_merge (
	// Lane error group
	port_err_if.merge lanes
);
	// A lane counts only once it has character sync, not link-up
	wire logic [3:0] qualified = lanes.lane_sync & lanes.lane_cause;
	// Every lane of the MAC feeds the even port's flag
	assign lanes.lane_hit = |qualified;
endmodule : lane_error_merge

// file: logic/link_signal_monitor.sv
`timescale 1ns/1ps
module link_signal_monitor
	import serial_port_error_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Signal detect group
	port_err_if.monitor mon
);
	monitor_state_type state_reg;   // Current monitor state
	monitor_state_type state_next;  // Next monitor state
	logic              ret_reg;     // Registered return pulse

	// Watches for signal seen, lost in the silent period, then back
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			MON_IDLE: begin
				if (mon.sig_present && !mon.link_up) begin
					state_next = MON_SEEN;
				end
			end
			MON_SEEN: begin
				if (mon.link_up) begin
					state_next = MON_IDLE;
				end else if (!mon.sig_present) begin
					state_next = MON_LOST;
				end
			end
			MON_LOST: begin
				if (mon.sig_present) begin
					state_next = MON_SEEN;
				end
			end
			default: begin
				state_next = MON_IDLE;
			end
		endcase
	end

	// State and pulse flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= MON_IDLE;
			ret_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			ret_reg   <= (state_reg == MON_LOST) && mon.sig_present;
		end
	end

	assign mon.sig_returned = ret_reg;

	// Return pulse only follows a lost phase
	return_after_loss_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n) ret_reg |-> $past(state_reg) == MON_LOST)
		else $error("return pulse without prior signal loss");
endmodule : link_signal_monitor

// file: logic/serial_port_error_and_discard.sv
// Notes on behaviour
// - Writing send zero leaves done set
// - Narrow mode drives only one lane
// - Signal seen, lost, returned raises error
// - Port error also raises vendor fault
// - Errors never block packets after link-up
// - Status one-clears, vendor fault zero-clears
// - Odd port error also flags even port
// - Even flag ORs all lane causes
// - Lane causes gated by character sync
// - Even flag harmless, cleared by zero
// - Odd error makes both ports port-write
// - Standard discard while rate over threshold
// - Dead-link discard ends at reinitialisation
// - Ackid mismatch stops standard discard
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module serial_port_error_and_discard
	import serial_port_error_pkg::*;
#(
	parameter int unsigned LOCK_DEADLINE = LOCK_DEADLINE_CYC
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Lane and link status
	input  wire logic [LANES-1:0]  lane_sync,
	input  wire logic [LANES-1:0]  lane_err_cause,
	input  wire logic              rx_signal,
	input  wire logic              link_up_even,
	input  wire logic              link_up_odd,
	input  wire logic              odd_err_event,
	input  wire logic              ackid_mismatch,
	input  wire logic              dead_link_expired,
	input  wire logic [RATE_W-1:0] error_rate_count,
	input  wire logic              mcs_sent,
	// Link control
	output logic                   mcs_send,
	output logic [LANES-1:0]       lane_tx_enable,
	output logic                   pkt_enable_even,
	output logic                   pkt_enable_odd,
	output logic                   discard_pkt,
	output logic                   pw_req_even,
	output logic                   pw_req_odd,
	// Interrupt
	output logic                   irq
);
	// Set by hardware, cleared one way or the other by software
	function automatic logic clr1(input logic cur, input logic set,
		input logic wr, input logic wbit);
		clr1 = set | (cur & ~(wr & wbit));
	endfunction : clr1

	function automatic logic clr0(input logic cur, input logic set,
		input logic wr, input logic wbit);
		clr0 = set | (cur & ~(wr & ~wbit));
	endfunction : clr0

	port_err_if pe ();  // Carrier to the two helpers

	assign pe.lane_sync   = lane_sync;
	assign pe.lane_cause  = lane_err_cause;
	assign pe.sig_present = rx_signal;
	assign pe.link_up     = link_up_even;

	lane_error_merge u_merge (
		.lanes (pe.merge)
	);

	link_signal_monitor u_monitor (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.mon     (pe.monitor)
	);

	// State
	logic              pready_reg;      // Access answer
	logic              pslverr_reg;     // Unmapped address
	logic [31:0]       prdata_reg;      // Captured read word
	logic              done_reg;        // Multicast symbol done
	logic              send_reg;        // Multicast send pulse
	logic              st_err_even_reg; // Status error, even
	logic              st_err_odd_reg;  // Status error, odd
	logic              pw_even_reg;     // Port-write pending, even
	logic              pw_odd_reg;      // Port-write pending, odd
	logic              det_err_even_reg;// Detect error, even
	logic              det_err_odd_reg; // Detect error, odd
	logic              vnd_even_reg;    // Vendor fault, even
	logic              vnd_odd_reg;     // Vendor fault, odd
	logic              oes_reg;         // Output error-stopped
	logic              dead_reg;        // Dead-link discard active
	logic              up_q_reg;        // Link-up one cycle ago
	logic              over_q_reg;      // Rate over one cycle ago
	logic [CTRL_W-1:0] ctrl_reg;        // Port control
	logic [RATE_W-1:0] thresh_reg;      // Failure threshold
	logic [IRQ_W-1:0]  irq_stat_reg;    // Sticky events
	logic [IRQ_W-1:0]  irq_mask_reg;    // Event enables
	logic              dl_active_reg;   // Lock deadline running
	logic [DL_W-1:0]   dl_cnt_reg;      // Lock deadline count
	logic [LANES-1:0]  tx_reg;          // Lane drive enables
	logic              pkt_even_reg;    // Even port may pass packets
	logic              pkt_odd_reg;     // Odd port may pass packets
	logic              discard_reg;     // Discard packets
	logic              pwq_even_reg;    // Port-write request, even
	logic              pwq_odd_reg;     // Port-write request, odd
	logic              irq_reg;         // Interrupt line

	// APB decode: one wait state, then the answer cycle
	wire logic acc     = psel & penable & ~pready_reg;
	wire logic fin     = psel & penable & pready_reg;
	wire logic wr      = fin & pwrite;
	wire logic hit_mcs = paddr == ADDR_MCS;
	wire logic hit_st  = paddr == ADDR_STATUS;
	wire logic hit_det = paddr == ADDR_DETECT;
	wire logic hit_ctl = paddr == ADDR_CTRL;
	wire logic hit_rt  = paddr == ADDR_RATE;
	wire logic hit_th  = paddr == ADDR_THRESH;
	wire logic hit_is  = paddr == ADDR_IRQ_STAT;
	wire logic hit_im  = paddr == ADDR_IRQ_MASK;
	wire logic mapped  = hit_mcs | hit_st | hit_det | hit_ctl | hit_rt
		| hit_th | hit_is | hit_im;
	wire logic wr_mcs  = wr & hit_mcs;
	wire logic wr_st   = wr & hit_st;
	wire logic wr_det  = wr & hit_det;

	// Control fields
	wire logic drop_en   = ctrl_reg[CTL_DROP_EN];
	wire logic stop_fail = ctrl_reg[CTL_STOP_FAIL];
	wire logic dead_en   = ctrl_reg[CTL_DEAD_EN];
	wire logic port_lock_bit      = ctrl_reg[CTL_LOCK];
	wire logic port_err_en        = ctrl_reg[CTL_PERR_EN];
	wire logic port_write_disable = ctrl_reg[CTL_PORT_WRITE_DISABLE];
	wire logic narrow    = ctrl_reg[CTL_NARROW];
	wire logic dual      = ctrl_reg[CTL_DUAL];

	// Error events; the even port shares the MAC with the odd one
	wire logic odd_share = dual & odd_err_event;
	wire logic set_even  = pe.sig_returned | pe.lane_hit | odd_share;
	wire logic set_odd   = odd_err_event;
	wire logic pw_fire   = odd_err_event & dual & port_err_en
		& ~port_write_disable;

	// Discard terms
	wire logic rate_over = error_rate_count > thresh_reg;
	wire logic std_disc  = drop_en & stop_fail & rate_over & ~oes_reg;
	wire logic reinit    = link_up_even & ~up_q_reg;
	// Expiry beats reinit in the same cycle so a dead link is never missed
	wire logic dead_next = (dead_en & dead_link_expired)
		| (dead_reg & ~reinit);
	wire logic disc_next = std_disc | dead_next | port_lock_bit;

	// Lock deadline: warns when the lock bit arrives too late
	wire logic dl_end    = dl_cnt_reg == DL_W'(LOCK_DEADLINE - 1);
	wire logic late      = dl_active_reg & dl_end & ~port_lock_bit;

	// Sticky interrupt events
	wire logic [IRQ_W-1:0] irq_set = {mcs_sent, late,
		rate_over & ~over_q_reg, set_odd, set_even};
	wire logic [IRQ_W-1:0] irq_clr =
		(wr & hit_is) ? pwdata[IRQ_W-1:0] : IRQ_RST;

	// Lane drive; a narrow port never lights the other lanes
	wire logic [LANES-1:0] tx_next = narrow ? TX_ONE
		: (dual ? TX_DUAL : TX_ALL);

	// Read words
	wire logic [31:0] rd_mcs = {30'h0, done_reg, 1'b0};
	wire logic [31:0] rd_st  = {15'h0, oes_reg, 3'h0, pw_odd_reg, 2'h0,
		st_err_odd_reg, link_up_odd, 3'h0, pw_even_reg, 2'h0,
		st_err_even_reg, link_up_even};
	wire logic [31:0] rd_det = {22'h0, vnd_odd_reg, det_err_odd_reg, 6'h0,
		vnd_even_reg, det_err_even_reg};
	wire logic [31:0] rd_word =
		hit_mcs ? rd_mcs :
		hit_st  ? rd_st :
		hit_det ? rd_det :
		hit_ctl ? {24'h0, ctrl_reg} :
		hit_rt  ? {24'h0, error_rate_count} :
		hit_th  ? {24'h0, thresh_reg} :
		hit_is  ? {27'h0, irq_stat_reg} :
		hit_im  ? {27'h0, irq_mask_reg} : 32'h0;

	// Bus answer flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end else begin
			pready_reg  <= acc;
			pslverr_reg <= acc & ~mapped;
			if (acc) begin
				prdata_reg <= rd_word;
			end
		end
	end

	// Multicast symbol send; a write with send low leaves done alone
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= MCS_DONE_RST;
			send_reg <= 1'b0;
		end else begin
			done_reg <= clr1(done_reg, mcs_sent, wr_mcs,
				pwdata[MCS_SEND_BIT]);
			send_reg <= wr_mcs & pwdata[MCS_SEND_BIT];
		end
	end

	// Error flags: sticky, set wins over a same-cycle clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_err_even_reg  <= 1'b0;
			st_err_odd_reg   <= 1'b0;
			det_err_even_reg <= 1'b0;
			det_err_odd_reg  <= 1'b0;
			vnd_even_reg     <= 1'b0;
			vnd_odd_reg      <= 1'b0;
		end else begin
			st_err_even_reg  <= clr1(st_err_even_reg, set_even, wr_st,
				pwdata[ST_ERR_EVEN]);
			st_err_odd_reg   <= clr1(st_err_odd_reg, set_odd, wr_st,
				pwdata[ST_ERR_ODD]);
			det_err_even_reg <= clr0(det_err_even_reg, set_even, wr_det,
				pwdata[DET_ERR_EVEN]);
			det_err_odd_reg  <= clr0(det_err_odd_reg, set_odd, wr_det,
				pwdata[DET_ERR_ODD]);
			vnd_even_reg     <= clr0(vnd_even_reg, set_even, wr_det,
				pwdata[DET_VND_EVEN]);
			vnd_odd_reg      <= clr0(vnd_odd_reg, set_odd, wr_det,
				pwdata[DET_VND_ODD]);
		end
	end

	// Port-writes from both ports on an odd-port error
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pw_even_reg  <= 1'b0;
			pw_odd_reg   <= 1'b0;
			pwq_even_reg <= 1'b0;
			pwq_odd_reg  <= 1'b0;
		end else begin
			pw_even_reg  <= clr1(pw_even_reg, pw_fire, wr_st,
				pwdata[ST_PW_EVEN]);
			pw_odd_reg   <= clr1(pw_odd_reg, pw_fire, wr_st,
				pwdata[ST_PW_ODD]);
			pwq_even_reg <= pw_fire;
			pwq_odd_reg  <= pw_fire;
		end
	end

	// Output error-stop and the discard decision
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			oes_reg     <= 1'b0;
			dead_reg    <= 1'b0;
			up_q_reg    <= 1'b0;
			over_q_reg  <= 1'b0;
			discard_reg <= 1'b0;
		end else begin
			oes_reg     <= clr1(oes_reg, ackid_mismatch, wr_st,
				pwdata[ST_OES]);
			dead_reg    <= dead_next;
			up_q_reg    <= link_up_even;
			over_q_reg  <= rate_over;
			discard_reg <= disc_next;
		end
	end

	// Software registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg     <= CTRL_RST;
			thresh_reg   <= THRESH_RST;
			irq_stat_reg <= IRQ_RST;
			irq_mask_reg <= IRQ_RST;
		end else begin
			if (wr & hit_ctl) begin
				ctrl_reg <= pwdata[CTRL_W-1:0];
			end
			if (wr & hit_th) begin
				thresh_reg <= pwdata[RATE_W-1:0];
			end
			if (wr & hit_im) begin
				irq_mask_reg <= pwdata[IRQ_W-1:0];
			end
			irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
		end
	end

	// Deadline counter, restarted by each port-write while the lock bit is clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dl_active_reg <= 1'b0;
			dl_cnt_reg    <= '0;
		end else if (pw_fire & ~port_lock_bit) begin
			dl_active_reg <= 1'b1;
			dl_cnt_reg    <= '0;
		end else if (dl_active_reg & (port_lock_bit | dl_end)) begin
			dl_active_reg <= 1'b0;
		end else if (dl_active_reg) begin
			dl_cnt_reg    <= dl_cnt_reg + 16'h0001;
		end
	end

	// Link-facing outputs; packet flow depends on link-up only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_reg       <= TX_ALL;
			pkt_even_reg <= 1'b0;
			pkt_odd_reg  <= 1'b0;
			irq_reg      <= 1'b0;
		end else begin
			tx_reg       <= tx_next;
			pkt_even_reg <= link_up_even;
			pkt_odd_reg  <= link_up_odd;
			irq_reg      <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	assign prdata          = prdata_reg;
	assign pready          = pready_reg;
	assign pslverr         = pslverr_reg;
	assign mcs_send        = send_reg;
	assign lane_tx_enable  = tx_reg;
	assign pkt_enable_even = pkt_even_reg;
	assign pkt_enable_odd  = pkt_odd_reg;
	assign discard_pkt     = discard_reg;
	assign pw_req_even     = pwq_even_reg;
	assign pw_req_odd      = pwq_odd_reg;
	assign irq             = irq_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence write_status_s;
		wr_st && pwdata[ST_ERR_EVEN];
	endsequence
	sequence reinit_s;
		reinit && !(dead_en && dead_link_expired) && !std_disc
			&& !port_lock_bit;
	endsequence

	mcs_done_keep_a: assert property (wr_mcs && !pwdata[MCS_SEND_BIT]
		&& done_reg |=> done_reg) else $error("done lost on send zero");
	narrow_one_lane_a: assert property (narrow |=>
		lane_tx_enable == 4'h1) else $error("narrow port drives lanes");
	return_sets_err_a: assert property (pe.sig_returned |=>
		st_err_even_reg) else $error("signal return missed");
	vendor_follows_a: assert property ($rose(st_err_even_reg) |->
		vnd_even_reg) else $error("vendor fault not raised");
	packets_flow_a: assert property (link_up_even ##1 link_up_even
		|-> pkt_enable_even) else $error("packets blocked by error");
	status_clear_a: assert property (write_status_s ##0 !set_even |=>
		!st_err_even_reg) else $error("status error not cleared");
	odd_to_even_a: assert property (odd_share |=>
		det_err_even_reg && st_err_even_reg) else $error("even not flagged");
	lane_merge_a: assert property (|(lane_sync & lane_err_cause) |=>
		det_err_even_reg) else $error("lane cause not merged");
	both_port_write_a: assert property (pw_fire |=> pw_req_even
		&& pw_req_odd && pw_even_reg && pw_odd_reg)
		else $error("port-write pair missing");
	std_discard_a: assert property (std_disc |=> discard_pkt)
		else $error("standard discard missing");
	dead_stop_a: assert property (reinit_s |=> !discard_pkt)
		else $error("dead discard survives reinit");
	oes_blocks_a: assert property (ackid_mismatch |=> oes_reg
		&& !std_disc) else $error("stopped port still discards");
	sticky_a: assert property (st_err_even_reg && !wr_st |=>
		st_err_even_reg) else $error("error flag dropped");
endmodule : serial_port_error_and_discard

// file: bench/link_partner.sv
`timescale 1ns/1ps
module link_partner
	import serial_port_error_pkg::*;
(
	// Clock
	input  wire logic              ref_clk,
	// Lane and link state seen by the port
	output logic [LANES-1:0]       lane_sync,
	output logic [LANES-1:0]       lane_err_cause,
	output logic                   rx_signal,
	output logic                   link_up_even,
	output logic                   link_up_odd,
	output logic [RATE_W-1:0]      error_rate_count,
	// One-cycle events: odd error, ackid, dead link, symbol sent
	output logic [3:0]             ev
);
	// Quiet link, no sync, no events
	initial begin
		lane_sync = 4'h0;
		lane_err_cause = 4'h0;
		rx_signal = 1'b0;
		link_up_even = 1'b0;
		link_up_odd = 1'b0;
		error_rate_count = 8'h00;
		ev = 4'h0;
	end
	// Wide partner: first try, silence, then narrow start-up
	task automatic fallback();
		@(posedge ref_clk);
		rx_signal <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rx_signal <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rx_signal <= 1'b1;
		repeat (4) @(posedge ref_clk);
		link_up_even <= 1'b1;
		link_up_odd <= 1'b1;
	endtask : fallback
	// One event, exactly one cycle wide
	task automatic pulse(input int unsigned idx);
		@(posedge ref_clk);
		ev <= 4'h1 << idx;
		@(posedge ref_clk);
		ev <= 4'h0;
	endtask : pulse
	// Link drops and comes back, as after a partner reset
	task automatic reinit();
		@(posedge ref_clk);
		link_up_even <= 1'b0;
		repeat (4) @(posedge ref_clk);
		link_up_even <= 1'b1;
	endtask : reinit
endmodule : link_partner

// file: bench/tb.sv
`timescale 1ns/1ps
module tb
	import serial_port_error_pkg::*;
;
	logic        ref_clk, rst_n, psel, penable, pwrite, perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, mcs_send, pkt_e, pkt_o, discard;
	logic        pw_e, pw_o, irq;
	logic [3:0]  tx_en;
	wire  [3:0]  sync, cause, ev;
	wire         rx, up_e, up_o;
	wire  [7:0]  rate;
	int          bad_count, n_tests;

	// Short deadline keeps the late-lock path reachable in a short run
	serial_port_error_and_discard #(.LOCK_DEADLINE(40)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lane_sync(sync),
		.lane_err_cause(cause), .rx_signal(rx), .link_up_even(up_e),
		.link_up_odd(up_o), .odd_err_event(ev[0]), .ackid_mismatch(ev[1]),
		.dead_link_expired(ev[2]), .error_rate_count(rate),
		.mcs_sent(ev[3]), .mcs_send(mcs_send), .lane_tx_enable(tx_en),
		.pkt_enable_even(pkt_e), .pkt_enable_odd(pkt_o),
		.discard_pkt(discard), .pw_req_even(pw_e), .pw_req_odd(pw_o),
		.irq(irq));
	link_partner lp (.ref_clk(ref_clk), .lane_sync(sync),
		.lane_err_cause(cause), .rx_signal(rx), .link_up_even(up_e),
		.link_up_odd(up_o), .error_rate_count(rate), .ev(ev));

	// 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value at %0t ns: got %h expected %h",
				$time, got, exp);
			bad_count++;
		end
	endtask : chk

	task automatic test_done();
		$display("mismatches %0d, checks %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	// One APB transfer; pready and the answer are taken at the rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			bad_count++;
			test_done();
		end
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	// Masked read compare
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat & m, e);
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : settle

	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		bad_count = 0;
		n_tests = 0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		settle(1);
		chk(32'(tx_en), 32'hf);
		rd(ADDR_THRESH, 32'hff, 32'hff);
		wr(ADDR_MCS, 32'h0);
		rd(ADDR_MCS, 32'h2, 32'h2);
		wr(ADDR_MCS, 32'h1);
		settle(1);
		chk(32'(mcs_send), 32'h1);
		rd(ADDR_MCS, 32'h2, 32'h0);
		lp.pulse(3);
		rd(ADDR_MCS, 32'h2, 32'h2);
		wr(ADDR_CTRL, 32'h1 << CTL_NARROW);
		settle(2);
		chk(32'(tx_en), 32'h1);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_IRQ_MASK, 32'h1);
		lp.fallback();
		settle(3);
		rd(ADDR_STATUS, 32'h3, 32'h3);
		rd(ADDR_DETECT, 32'h3, 32'h3);
		chk(32'(pkt_e), 32'h1);
		chk(32'(pkt_o), 32'h1);
		chk(32'(irq), 32'h1);
		rd(ADDR_STATUS, 32'h2, 32'h2);
		wr(ADDR_STATUS, 32'h2);
		wr(ADDR_DETECT, 32'h0);
		rd(ADDR_STATUS, 32'h2, 32'h0);
		rd(ADDR_DETECT, 32'h3, 32'h0);
		wr(ADDR_IRQ_STAT, 32'h1);
		settle(2);
		chk(32'(irq), 32'h0);
		// Cause on a lane that has not synced must not count
		@(posedge ref_clk);
		lp.lane_sync <= 4'hb;
		lp.lane_err_cause <= 4'h4;
		settle(3);
		rd(ADDR_DETECT, 32'h1, 32'h0);
		lp.lane_sync <= 4'hf;
		settle(3);
		rd(ADDR_DETECT, 32'h1, 32'h1);
		lp.lane_err_cause <= 4'h0;
		wr(ADDR_DETECT, 32'h0);
		wr(ADDR_STATUS, 32'h2);
		wr(ADDR_CTRL, (32'h1 << CTL_DUAL) | (32'h1 << CTL_PERR_EN));
		lp.pulse(0);
		settle(1);
		chk(32'({pw_e, pw_o}), 32'h3);
		settle(2);
		rd(ADDR_STATUS, 32'h1212, 32'h1212);
		rd(ADDR_DETECT, 32'h301, 32'h301);
		chk(32'(pkt_e), 32'h1);
		wr(ADDR_DETECT, 32'h0);
		rd(ADDR_DETECT, 32'h1, 32'h0);
		wr(ADDR_CTRL, 32'h1 << CTL_LOCK);
		settle(2);
		chk(32'(discard), 32'h1);
		rd(ADDR_IRQ_STAT, 32'h8, 32'h0);
		// Standard discard: count one above the threshold
		wr(ADDR_THRESH, 32'ha);
		lp.error_rate_count <= 8'h0b;
		wr(ADDR_CTRL, 32'h3);
		settle(2);
		chk(32'(discard), 32'h1);
		rd(ADDR_IRQ_STAT, 32'h4, 32'h4);
		lp.pulse(1);
		settle(2);
		chk(32'(discard), 32'h0);
		@(posedge ref_clk);
		lp.error_rate_count <= 8'h0a;
		wr(ADDR_STATUS, 32'h1 << ST_OES);
		settle(2);
		chk(32'(discard), 32'h0);
		wr(ADDR_CTRL, 32'h1 << CTL_DEAD_EN);
		lp.pulse(2);
		settle(2);
		chk(32'(discard), 32'h1);
		lp.reinit();
		settle(3);
		chk(32'(discard), 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(perr), 32'h1);
		chk(rdat, 32'h0);
		// Lock never set after a port-write: the late event must be flagged
		wr(ADDR_CTRL, (32'h1 << CTL_DUAL) | (32'h1 << CTL_PERR_EN));
		lp.pulse(0);
		settle(45);
		rd(ADDR_IRQ_STAT, 32'h8, 32'h8);
		test_done();
	end
endmodule : tb
